/* rtl/tca_time_code_acquisition.sv */
// time code acquisition and internal real-time clock
`timescale 1ns/1ps
// Notes on behaviour
// - frames last one second, 100 pulses in fields; decoding follows that.
// - seconds, minutes, hours, day fields load the clock on acceptance.
// - start on sync command or auto schedule; take two back-to-back frames.
// - earlier frame is advanced one second before comparison.
// - disagreement discards the acquisition; clock is left unchanged.
// - automatic acquisition repeats about every five minutes.
// - acquisition stops ten minutes before year-end midnight.
// - acquisition resumes ten minutes after that midnight.
module tca_time_code_acquisition #(
  parameter logic [17:0] MIN_CYC      = 18'(tca_pkg::MIN_CYC),
  parameter logic [17:0] ZERO_MAX_CYC = 18'(tca_pkg::ZERO_MAX_CYC),
  parameter logic [17:0] ONE_MAX_CYC  = 18'(tca_pkg::ONE_MAX_CYC),
  parameter logic [17:0] MARK_MAX_CYC = 18'(tca_pkg::MARK_MAX_CYC),
  parameter logic [24:0] SECOND_CYC   = 25'(tca_pkg::SECOND_CYC)
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  // time code pins
  input  wire logic                   time_code_in_pos,
  input  wire logic                   time_code_in_neg,
  // control
  input  wire logic                   time_sync_command,
  input  wire logic                   autoEnable,
  input  wire logic                   yearIsLeap,
  // clock and status
  output tca_pkg::tca_time_type       rtcTime,
  output logic                        secondTick,
  output logic                        acqBusy,
  output logic                        acqAccepted,
  output logic                        acqError,
  output logic                        acqSuspended,
  output logic                        frameLocked
);

  logic                          sync1, sync2, sync3, lineLevel;
  logic                          next_lineLevel;
  logic                          symValid;
  tca_pkg::tca_sym_type          symKind;
  logic                          prevMark, frameDone, lockLost;
  logic [6:0]                    pos;
  logic [tca_pkg::BITS_W-1:0]    bits;
  logic                          next_prevMark, next_locked;
  logic                          next_frameDone, next_lockLost;
  logic [6:0]                    next_pos;
  logic [tca_pkg::BITS_W-1:0]    next_bits;
  logic                          isMark, expectMark;
  logic [24:0]                   subCnt, next_subCnt;
  tca_pkg::tca_time_type         next_rtcTime;
  logic                          next_secondTick;
  tca_pkg::tca_acq_state_type    acqState, next_acqState;
  tca_pkg::tca_time_type         firstTime, next_firstTime;
  tca_pkg::tca_time_type         loadTime, next_loadTime;
  tca_pkg::tca_time_type         decoded;
  logic                          loadReq, next_loadReq;
  logic [8:0]                    timeoutSecs, next_timeoutSecs;
  logic [8:0]                    autoSecs, next_autoSecs;
  logic                          next_acqAccepted, next_acqError;
  logic                          next_acqSuspended, inWindow, autoDue;
  logic [8:0]                    yearLen;

  // ==========================================================================
  // line input: the demodulated level is the difference of the two lines
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1     <= 1'b0;
      sync2     <= 1'b0;
      sync3     <= 1'b0;
      lineLevel <= 1'b0;
    end else begin
      sync1     <= time_code_in_pos & ~time_code_in_neg;
      sync2     <= sync1;
      sync3     <= sync2;
      lineLevel <= next_lineLevel;
    end
  end

  // a change only counts once two stages agree
  always_comb begin
    next_lineLevel = (sync2 == sync3) ? sync3 : lineLevel;
  end

  tca_pulse_classifier #(
    .MIN_CYC      (MIN_CYC),
    .ZERO_MAX_CYC (ZERO_MAX_CYC),
    .ONE_MAX_CYC  (ONE_MAX_CYC),
    .MARK_MAX_CYC (MARK_MAX_CYC)
  ) u_classifier (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .lineLevel (lineLevel),
    .symValid  (symValid),
    .symKind   (symKind)
  );

  // ==========================================================================
  // frame alignment and bit capture
  assign isMark     = (symKind == tca_pkg::SYM_MARK);
  assign expectMark = (pos == 7'h00)
                   || ((pos % tca_pkg::POS_RADIX) == tca_pkg::MARK_REM);

  always_comb begin
    next_prevMark  = prevMark;
    next_locked    = frameLocked;
    next_pos       = pos;
    next_bits      = bits;
    next_frameDone = 1'b0;
    next_lockLost  = 1'b0;
    if (symValid) begin
      next_prevMark = isMark;
      if (symKind == tca_pkg::SYM_BAD) begin
        next_locked   = 1'b0;
        next_lockLost = frameLocked;
      end else if (!frameLocked) begin
        if (isMark && prevMark) begin
          next_locked = 1'b1;
          next_pos    = tca_pkg::POS_FIRST_DATA;
        end
      end else if (isMark != expectMark) begin
        next_locked   = 1'b0;
        next_lockLost = 1'b1;
      end else begin
        if (pos < tca_pkg::BITS_KEPT) begin
          next_bits[pos[5:0]] = (symKind == tca_pkg::SYM_ONE);
        end
        if (pos == tca_pkg::FRAME_LAST_POS) begin
          next_frameDone = 1'b1;
          next_pos       = 7'h00;
        end else begin
          next_pos = pos + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prevMark    <= 1'b0;
      frameLocked <= 1'b0;
      pos         <= 7'h00;
      bits        <= '0;
      frameDone   <= 1'b0;
      lockLost    <= 1'b0;
    end else begin
      prevMark    <= next_prevMark;
      frameLocked <= next_locked;
      pos         <= next_pos;
      bits        <= next_bits;
      frameDone   <= next_frameDone;
      lockLost    <= next_lockLost;
    end
  end

  // ==========================================================================
  // internal real-time clock
  assign yearLen = yearIsLeap ? tca_pkg::LEAP_DAYS : tca_pkg::YEAR_DAYS;

  always_comb begin
    next_subCnt     = subCnt + 25'h0000001;
    next_rtcTime    = rtcTime;
    next_secondTick = 1'b0;
    if (loadReq) begin
      next_rtcTime = loadTime;
      next_subCnt  = 25'h0000000;
    end else if (subCnt == SECOND_CYC - 25'h0000001) begin
      // free-running between acquisitions, also after a discard
      next_subCnt     = 25'h0000000;
      next_rtcTime    = tca_pkg::tca_time_incr(rtcTime, yearLen);
      next_secondTick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      subCnt     <= 25'h0000000;
      rtcTime    <= tca_pkg::TIME_RESET;
      secondTick <= 1'b0;
    end else begin
      subCnt     <= next_subCnt;
      rtcTime    <= next_rtcTime;
      secondTick <= next_secondTick;
    end
  end

  // ==========================================================================
  // acquisition sequencing
  assign decoded = tca_pkg::tca_decode(bits);
  // early part only extends a year-end hold; a reset to day one must not
  // block acquisition for ten minutes
  assign inWindow =
      ((rtcTime.day == yearLen) && (rtcTime.hour == tca_pkg::HOUR_MAX)
        && (rtcTime.min >= tca_pkg::SUSPEND_MIN))
   || (acqSuspended && (rtcTime.day == tca_pkg::DAY_FIRST)
        && (rtcTime.hour == tca_pkg::MIDNIGHT_HR)
        && (rtcTime.min < tca_pkg::RESUME_MIN));
  assign autoDue  = autoEnable && secondTick
                 && (autoSecs == tca_pkg::AUTO_LAST_SEC);
  assign acqBusy  = (acqState != tca_pkg::ACQ_IDLE);

  always_comb begin
    next_acqState     = acqState;
    next_firstTime    = firstTime;
    next_loadTime     = loadTime;
    next_loadReq      = 1'b0;
    next_acqAccepted  = 1'b0;
    next_acqError     = 1'b0;
    next_acqSuspended = inWindow;
    next_timeoutSecs  = timeoutSecs;
    next_autoSecs     = autoSecs;
    if (!autoEnable || autoDue) begin
      next_autoSecs = 9'h000;
    end else if (secondTick) begin
      next_autoSecs = autoSecs + 9'h001;
    end
    if (acqBusy && secondTick) begin
      next_timeoutSecs = timeoutSecs + 9'h001;
    end
    if (acqBusy && acqSuspended) begin
      next_acqState = tca_pkg::ACQ_IDLE;
    end else if (acqBusy && (timeoutSecs >= tca_pkg::ACQ_TIMEOUT_SEC)) begin
      // no usable frame pair arrived in time
      next_acqState = tca_pkg::ACQ_IDLE;
      next_acqError = 1'b1;
    end else begin
      case (acqState)
        tca_pkg::ACQ_IDLE: begin
          if ((time_sync_command || autoDue) && !acqSuspended) begin
            next_acqState    = tca_pkg::ACQ_FIRST;
            next_timeoutSecs = 9'h000;
          end
        end
        tca_pkg::ACQ_FIRST: begin
          if (frameDone) begin
            next_firstTime = decoded;
            next_acqState  = tca_pkg::ACQ_SECOND;
          end
        end
        tca_pkg::ACQ_SECOND: begin
          if (lockLost) begin
            // frames would no longer be back to back
            next_acqState = tca_pkg::ACQ_IDLE;
            next_acqError = 1'b1;
          end else if (frameDone) begin
            next_acqState = tca_pkg::ACQ_IDLE;
            if ((tca_pkg::tca_time_incr(firstTime, yearLen) == decoded)
                && tca_pkg::tca_time_ok(decoded, yearLen)) begin
              // frame time is its start, so the clock takes the next second
              next_loadTime    = tca_pkg::tca_time_incr(decoded, yearLen);
              next_loadReq     = 1'b1;
              next_acqAccepted = 1'b1;
            end else begin
              next_acqError = 1'b1;
            end
          end
        end
        default: begin
          next_acqState = tca_pkg::ACQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acqState     <= tca_pkg::ACQ_IDLE;
      firstTime    <= tca_pkg::TIME_RESET;
      loadTime     <= tca_pkg::TIME_RESET;
      loadReq      <= 1'b0;
      acqAccepted  <= 1'b0;
      acqError     <= 1'b0;
      acqSuspended <= 1'b0;
      timeoutSecs  <= 9'h000;
      autoSecs     <= 9'h000;
    end else begin
      acqState     <= next_acqState;
      firstTime    <= next_firstTime;
      loadTime     <= next_loadTime;
      loadReq      <= next_loadReq;
      acqAccepted  <= next_acqAccepted;
      acqError     <= next_acqError;
      acqSuspended <= next_acqSuspended;
      timeoutSecs  <= next_timeoutSecs;
      autoSecs     <= next_autoSecs;
    end
  end

endmodule : tca_time_code_acquisition

/* rtl/tca_pkg.sv */
// constants, types and helper functions for the time code acquisition block
package tca_pkg;

  // ==========================================================================
  // clock and pulse timing
  localparam int CLK_HZ        = 20000000;
  localparam int CYC_PER_US    = CLK_HZ / 1000000;
  localparam int T_MIN_US      = 1000;
  localparam int T_ZERO_MAX_US = 3500;
  localparam int T_ONE_MAX_US  = 6500;
  localparam int T_MARK_MAX_US = 9500;
  localparam int T_SECOND_US   = 1000000;
  // least and longest widths are plain products, no rounding
  localparam int MIN_CYC       = (T_MIN_US * CYC_PER_US + 0);
  localparam int ZERO_MAX_CYC  = T_ZERO_MAX_US * CYC_PER_US;
  localparam int ONE_MAX_CYC   = T_ONE_MAX_US * CYC_PER_US;
  localparam int MARK_MAX_CYC  = T_MARK_MAX_US * CYC_PER_US;
  localparam int SECOND_CYC    = T_SECOND_US * CYC_PER_US;
  localparam int PULSE_CNT_W   = 18;
  localparam int SUB_CNT_W     = 25;

  // ==========================================================================
  // frame layout
  localparam int         FRAME_PULSES   = 100;
  localparam logic [6:0] FRAME_LAST_POS = 7'h63;
  localparam logic [6:0] POS_FIRST_DATA = 7'h01;
  localparam logic [6:0] POS_RADIX      = 7'h0A;
  localparam logic [6:0] MARK_REM       = 7'h09;
  localparam logic [6:0] BITS_KEPT      = 7'h2A;
  localparam int         BITS_W         = 42;
  localparam int SEC_UNITS_LSB  = 1;
  localparam int SEC_TENS_LSB   = 6;
  localparam int MIN_UNITS_LSB  = 10;
  localparam int MIN_TENS_LSB   = 15;
  localparam int HOUR_UNITS_LSB = 20;
  localparam int HOUR_TENS_LSB  = 25;
  localparam int DAY_UNITS_LSB  = 30;
  localparam int DAY_TENS_LSB   = 35;
  localparam int DAY_HUND_LSB   = 40;

  // ==========================================================================
  // calendar limits and schedule
  localparam logic [5:0] SEC_MAX     = 6'h3B;
  localparam logic [5:0] MIN_MAX     = 6'h3B;
  localparam logic [4:0] HOUR_MAX    = 5'h17;
  localparam logic [8:0] DAY_FIRST   = 9'h001;
  localparam logic [8:0] YEAR_DAYS   = 9'h16D;
  localparam logic [8:0] LEAP_DAYS   = 9'h16E;
  localparam logic [5:0] SUSPEND_MIN = 6'h32;
  localparam logic [5:0] RESUME_MIN  = 6'h0A;
  localparam logic [4:0] MIDNIGHT_HR = 5'h00;
  localparam logic [8:0] AUTO_LAST_SEC   = 9'h12B;
  localparam logic [8:0] ACQ_TIMEOUT_SEC = 9'h004;

  // ==========================================================================
  // types
  typedef struct packed {
    logic [8:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } tca_time_type;

  localparam tca_time_type TIME_RESET = {9'h001, 5'h00, 6'h00, 6'h00};

  typedef enum logic [1:0] {
    SYM_ZERO = 2'b00,
    SYM_ONE  = 2'b01,
    SYM_MARK = 2'b10,
    SYM_BAD  = 2'b11
  } tca_sym_type;

  typedef enum logic [1:0] {
    ACQ_IDLE   = 2'b00,
    ACQ_FIRST  = 2'b01,
    ACQ_SECOND = 2'b10
  } tca_acq_state_type;

  // ==========================================================================
  // helpers
  function automatic tca_time_type tca_time_incr(input tca_time_type t,
                                                 input logic [8:0]   yearLen);
    tca_time_type r;
    r = t;
    if (t.sec != SEC_MAX) begin
      r.sec = t.sec + 6'h01;
    end else begin
      r.sec = 6'h00;
      if (t.min != MIN_MAX) begin
        r.min = t.min + 6'h01;
      end else begin
        r.min = 6'h00;
        if (t.hour != HOUR_MAX) begin
          r.hour = t.hour + 5'h01;
        end else begin
          r.hour = 5'h00;
          r.day  = (t.day >= yearLen) ? DAY_FIRST : t.day + 9'h001;
        end
      end
    end
    return r;
  endfunction : tca_time_incr

  function automatic tca_time_type tca_decode(input logic [BITS_W-1:0] b);
    tca_time_type r;
    r.sec  = 6'(b[SEC_TENS_LSB +: 3]) * 6'h0A + 6'(b[SEC_UNITS_LSB +: 4]);
    r.min  = 6'(b[MIN_TENS_LSB +: 3]) * 6'h0A + 6'(b[MIN_UNITS_LSB +: 4]);
    r.hour = 5'(b[HOUR_TENS_LSB +: 2]) * 5'h0A + 5'(b[HOUR_UNITS_LSB +: 4]);
    r.day  = 9'(b[DAY_HUND_LSB +: 2]) * 9'h064
           + 9'(b[DAY_TENS_LSB +: 4]) * 9'h00A + 9'(b[DAY_UNITS_LSB +: 4]);
    return r;
  endfunction : tca_decode

  function automatic logic tca_time_ok(input tca_time_type t,
                                       input logic [8:0]   yearLen);
    return (t.sec <= SEC_MAX) && (t.min <= MIN_MAX) && (t.hour <= HOUR_MAX)
        && (t.day >= DAY_FIRST) && (t.day <= yearLen);
  endfunction : tca_time_ok

endpackage : tca_pkg

/* rtl/tca_pulse_classifier.sv */
// pulse width classifier for the demodulated time code level
`timescale 1ns/1ps
module tca_pulse_classifier #(
  parameter logic [17:0] MIN_CYC      = 18'(tca_pkg::MIN_CYC),
  parameter logic [17:0] ZERO_MAX_CYC = 18'(tca_pkg::ZERO_MAX_CYC),
  parameter logic [17:0] ONE_MAX_CYC  = 18'(tca_pkg::ONE_MAX_CYC),
  parameter logic [17:0] MARK_MAX_CYC = 18'(tca_pkg::MARK_MAX_CYC)
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // filtered line level
  input  wire logic                 lineLevel,
  // classified symbol
  output logic                      symValid,
  output tca_pkg::tca_sym_type      symKind
);

  logic                 prevLevel;
  logic [17:0]          width;
  logic                 next_prevLevel;
  logic [17:0]          next_width;
  logic                 next_symValid;
  tca_pkg::tca_sym_type next_symKind;

  // ==========================================================================
  // width count and classification
  always_comb begin
    next_prevLevel = lineLevel;
    next_width     = width;
    next_symValid  = 1'b0;
    next_symKind   = symKind;
    if (lineLevel && !prevLevel) begin
      next_width = 18'h00001;
    end else if (lineLevel && (width <= MARK_MAX_CYC)) begin
      // saturates just past the marker limit
      next_width = width + 18'h00001;
    end
    if (!lineLevel && prevLevel) begin
      next_symValid = 1'b1;
      if (width < MIN_CYC) begin
        next_symKind = tca_pkg::SYM_BAD;
      end else if (width <= ZERO_MAX_CYC) begin
        next_symKind = tca_pkg::SYM_ZERO;
      end else if (width <= ONE_MAX_CYC) begin
        next_symKind = tca_pkg::SYM_ONE;
      end else if (width <= MARK_MAX_CYC) begin
        next_symKind = tca_pkg::SYM_MARK;
      end else begin
        next_symKind = tca_pkg::SYM_BAD;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prevLevel <= 1'b0;
      width     <= 18'h00000;
      symValid  <= 1'b0;
      symKind   <= tca_pkg::SYM_BAD;
    end else begin
      prevLevel <= next_prevLevel;
      width     <= next_width;
      symValid  <= next_symValid;
      symKind   <= next_symKind;
    end
  end

endmodule : tca_pulse_classifier

/* dv/tca_time_source.sv */
// behavioural demodulated time code source for the acquisition bench
`timescale 1ns/1ps
module tca_time_source #(
  parameter int SLOT   = 11,
  parameter int MARK_W = 8,
  parameter int ONE_W  = 5,
  parameter int ZERO_W = 2
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // frame content control
  input  wire logic             loadTime,
  input  tca_pkg::tca_time_type startTime,
  input  wire logic [5:0]       stepSec,
  output tca_pkg::tca_time_type doneTime,
  // differential level pins
  output logic                  time_code_in_pos,
  output logic                  time_code_in_neg
);
  tca_pkg::tca_time_type sendTime;
  tca_pkg::tca_time_type stepped;
  logic [99:0]           bits;
  logic                  pend;
  int                    cnt;
  int                    pos;
  int                    width;
  // ==========================================================================
  // frame contents, bcd digits lsb first
  always_comb begin
    bits = '0;
    bits[4:1] = 4'(sendTime.sec % 10);
    bits[8:6] = 3'(sendTime.sec / 10);
    bits[13:10] = 4'(sendTime.min % 10);
    bits[17:15] = 3'(sendTime.min / 10);
    bits[23:20] = 4'(sendTime.hour % 10);
    bits[26:25] = 2'(sendTime.hour / 10);
    bits[33:30] = 4'(sendTime.day % 10);
    bits[38:35] = 4'((sendTime.day / 10) % 10);
    bits[41:40] = 2'(sendTime.day / 100);
    width = (pos == 0 || pos % 10 == 9) ? MARK_W :
            (bits[pos] ? ONE_W : ZERO_W);
    stepped = sendTime;
    stepped.sec = sendTime.sec + stepSec;
  end
  // level only, no carrier; neg always the inverse
  assign time_code_in_pos = (cnt < width);
  assign time_code_in_neg = ~time_code_in_pos;
  // ==========================================================================
  // slot and frame counters, new content only at a frame boundary
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt <= 0;
      pos <= 0;
      pend <= 1'b0;
      sendTime <= startTime;
      doneTime <= startTime;
    end else begin
      pend <= pend | loadTime;
      cnt <= (cnt == SLOT - 1) ? 0 : cnt + 1;
      if (pos == 99 && cnt == MARK_W) begin
        doneTime <= sendTime;
      end
      if (cnt == SLOT - 1) begin
        pos <= (pos == 99) ? 0 : pos + 1;
        if (pos == 99) begin
          sendTime <= pend ? startTime : stepped;
          pend <= loadTime;
        end
      end
    end
  end
endmodule : tca_time_source

/* dv/tca_acq_checker.sv */
// port assertions for the time code acquisition block
`timescale 1ns/1ps
module tca_acq_checker (
  // clock and reset
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  // pins and control
  input wire logic             time_code_in_pos,
  input wire logic             time_code_in_neg,
  input wire logic             time_sync_command,
  input wire logic             autoEnable,
  input wire logic             yearIsLeap,
  // clock and status
  input tca_pkg::tca_time_type rtcTime,
  input wire logic             secondTick,
  input wire logic             acqBusy,
  input wire logic             acqAccepted,
  input wire logic             acqError,
  input wire logic             acqSuspended,
  input wire logic             frameLocked
);
  logic inWin;
  // ==========================================================================
  // year-end window on both sides of midnight
  always_comb begin
    inWin = (rtcTime.day == (yearIsLeap ? tca_pkg::LEAP_DAYS
                                        : tca_pkg::YEAR_DAYS)
             && rtcTime.hour == tca_pkg::HOUR_MAX
             && rtcTime.min >= tca_pkg::SUSPEND_MIN)
         || (acqSuspended && rtcTime.day == tca_pkg::DAY_FIRST
             && rtcTime.hour == tca_pkg::MIDNIGHT_HR
             && rtcTime.min < tca_pkg::RESUME_MIN);
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // assertions
  a_suspend_window: assert property (
    !$past(sys_rst) |-> acqSuspended == $past(inWin))
    else $error("suspend flag disagrees with clock window");
  a_start_not_suspended: assert property (
    $rose(acqBusy) |-> !$past(acqSuspended))
    else $error("acquisition started while suspended");
  a_result_exclusive: assert property (!(acqAccepted && acqError))
    else $error("accept and error together");
  a_result_from_busy: assert property (
    (acqAccepted || acqError) |-> $past(acqBusy) && !acqBusy)
    else $error("result without a running acquisition");
  a_accept_needs_lock: assert property (
    acqAccepted |-> $past(frameLocked))
    else $error("accept without frame alignment");
  a_load_restarts_second: assert property (
    acqAccepted |=> !secondTick [*8])
    else $error("second tick too soon after time load");
  a_error_keeps_time: assert property (
    acqError |-> ##2 rtcTime.hour == $past(rtcTime.hour, 2))
    else $error("clock changed after discarded acquisition");
  a_tick_spacing: assert property (secondTick |=> !secondTick [*8])
    else $error("second ticks too close");
  c_accept: cover property (acqAccepted);
  c_error: cover property (acqError);
  c_resume: cover property ($fell(acqSuspended));
endmodule : tca_acq_checker

bind tca_time_code_acquisition tca_acq_checker u_tca_acq_checker (
  .clk_sys(clk_sys), .sys_rst(sys_rst),
  .time_code_in_pos(time_code_in_pos), .time_code_in_neg(time_code_in_neg),
  .time_sync_command(time_sync_command), .autoEnable(autoEnable),
  .yearIsLeap(yearIsLeap), .rtcTime(rtcTime), .secondTick(secondTick),
  .acqBusy(acqBusy), .acqAccepted(acqAccepted), .acqError(acqError),
  .acqSuspended(acqSuspended), .frameLocked(frameLocked)
);

/* dv/test_tca_time_code_acquisition.sv */
// self-checking bench for the time code acquisition block
`timescale 1ns/1ps
module test_tca_time_code_acquisition;
  typedef struct packed {
    tca_pkg::tca_time_type start;
    logic [5:0]            step;
    logic                  accept;
  } tca_row_type;
  localparam int FRAME = 1100;
  logic                  clk_sys;
  logic                  sys_rst;
  logic                  timePos;
  logic                  timeNeg;
  logic                  time_sync_command;
  logic                  autoEnable;
  logic                  yearIsLeap;
  tca_pkg::tca_time_type rtcTime;
  logic                  secondTick;
  logic                  acqBusy;
  logic                  acqAccepted;
  logic                  acqError;
  logic                  acqSuspended;
  logic                  frameLocked;
  logic                  loadTime;
  tca_pkg::tca_time_type startTime;
  logic [5:0]            stepSec;
  tca_pkg::tca_time_type doneTime;
  tca_pkg::tca_time_type expTime;
  tca_row_type           rows [2];
  int                    fails;
  int                    checks_done;
  int                    n;
  // ==========================================================================
  // design and source; short widths keep a frame at one internal second
  tca_time_code_acquisition #(
    .MIN_CYC(18'h00001), .ZERO_MAX_CYC(18'h00003), .ONE_MAX_CYC(18'h00006),
    .MARK_MAX_CYC(18'h00009), .SECOND_CYC(25'h000044C)
  ) u_tca_time_code_acquisition (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .time_code_in_pos(timePos),
    .time_code_in_neg(timeNeg), .time_sync_command(time_sync_command),
    .autoEnable(autoEnable), .yearIsLeap(yearIsLeap), .rtcTime(rtcTime),
    .secondTick(secondTick), .acqBusy(acqBusy), .acqAccepted(acqAccepted),
    .acqError(acqError), .acqSuspended(acqSuspended),
    .frameLocked(frameLocked)
  );
  tca_time_source u_tca_time_source (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .loadTime(loadTime),
    .startTime(startTime), .stepSec(stepSec), .doneTime(doneTime),
    .time_code_in_pos(timePos), .time_code_in_neg(timeNeg)
  );
  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [25:0] seen,
                       input logic [25:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic tick(input int cyc);
    repeat (cyc) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic sync_cmd();
    @(posedge clk_sys);
    time_sync_command <= 1'b1;
    @(posedge clk_sys);
    time_sync_command <= 1'b0;
    #1;
  endtask : sync_cmd
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // hang guard, about twice the length of the whole run
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    test_done();
  end
  // ==========================================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    time_sync_command = 1'b0;
    autoEnable = 1'b0;
    yearIsLeap = 1'b0;
    loadTime = 1'b0;
    startTime = tca_pkg::TIME_RESET;
    stepSec = 6'h00;
    fails = 0;
    checks_done = 0;
    // frames two seconds apart, then a clean pair just before year end
    rows[0] = {9'h001, 5'h00, 6'h0A, 6'h00, 6'h02, 1'b0};
    rows[1] = {9'h16D, 5'h17, 6'h31, 6'h32, 6'h01, 1'b1};
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    tick(1);
    check("rtcTime", rtcTime, tca_pkg::TIME_RESET);
    check("acqBusy", 26'(acqBusy), 26'h0);
    tick(4);
    check("acqSuspended", 26'(acqSuspended), 26'h0);
    // source repeats one time, so the pair is not one second apart
    sync_cmd();
    check("acqBusy", 26'(acqBusy), 26'h1);
    for (n = 0; n < 4 * FRAME && acqError !== 1'b1; n++) tick(1);
    check("acqError", 26'(acqError), 26'h1);
    tick(2);
    check("acqSuspended", 26'(acqSuspended), 26'h0);
    check("frameLocked", 26'(frameLocked), 26'h1);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      startTime <= rows[i].start;
      stepSec <= rows[i].step;
      loadTime <= 1'b1;
      @(posedge clk_sys);
      loadTime <= 1'b0;
      tick(2 * FRAME);
      sync_cmd();
      check("acqBusy", 26'(acqBusy), 26'h1);
      for (n = 0; n < 4 * FRAME && acqAccepted !== 1'b1
           && acqError !== 1'b1; n++) tick(1);
      check("acqAccepted", 26'(acqAccepted), 26'(rows[i].accept));
      check("acqError", 26'(acqError), 26'(!rows[i].accept));
      expTime = rows[i].accept ? doneTime : rtcTime;
      expTime.sec = rows[i].accept ? doneTime.sec + 6'h01 : 6'h00;
      tick(1);
      if (!rows[i].accept) begin
        tick(1);
        check("rtcTime", {rtcTime[25:6], 6'h00}, expTime);
      end else begin
        check("rtcTime", rtcTime, expTime);
      end
    end
    for (n = 0; n < 16 * FRAME && acqSuspended !== 1'b1; n++) tick(1);
    check("rtcTime", {rtcTime[25:6], 6'h00},
          {9'h16D, 5'h17, 6'h32, 6'h00});
    sync_cmd();
    check("acqBusy", 26'(acqBusy), 26'h0);
    test_done();
  end
endmodule : test_tca_time_code_acquisition
